// [ivlp_ctrl.sv]
// Interrupt vectoring, return stack and low-power mode control, with an
// AXI4-Lite register port. Assumes all event inputs except nmiPin and
// extResetPin come from logic on ref_clk.
// Function
// - Sixteen handler addresses held in top region
// - Power-up, external, watchdog reset use top vector
// - Pin NMI and oscillator fault share vector
// - Pin NMI always taken, never masked
// - Oscillator fault masked only by own enable
// - Pin bit one and timer receive share
// - Timer/port flags external, one maskable vector
// - Interrupt wakes; return restores prior mode
// - Full run: processor executes, peripherals free
// - Level zero: processor halted, clocks running
// - Level one: also frequency loop stopped
// - Level two: main clock and loop stopped
// - Level three: also oscillator dc generator off
// - Level four: crystal clock also stopped
// - Four status bits select power state
// - Module enables; registers always accessible
// - Shared vectors keep flags for handler
// - Sixteen registers, one-cycle register operation
`timescale 1ns/1ps
`include "ivlp_defines.svh"

module ivlp_ctrl
  import ivlp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Event sources.
  input  wire logic        nmiPin,
  input  wire logic        extResetPin,
  input  wire logic        wdtResetEvt,
  input  wire logic        oscFaultEvt,
  input  wire logic        pin0Evt,
  input  wire logic        pin1Evt,
  input  wire logic        timerRxEvt,
  input  wire logic        wdtEvt,
  input  wire logic        adcEvt,
  input  wire logic        btEvt,
  input  wire logic [5:0]  pin27Evt,
  input  wire logic        tpCounter1Flag,
  input  wire logic        tpCounter2Flag,
  input  wire logic        tpEnableEdgeFlag,
  // Processor core side.
  input  wire logic [15:0] corePc,
  input  wire logic        irqAck,
  input  wire logic        returnFromHandler,
  input  wire logic        regOpValid,
  input  wire logic [3:0]  regOpSrc,
  input  wire logic [3:0]  regOpDst,
  output logic             irqReq,
  output logic [3:0]       vecNum,
  output logic [15:0]      vecAddr,
  output logic [15:0]      handlerAddr,
  output logic [15:0]      returnPc,
  output logic [15:0]      regOpResult,
  // Power and module control.
  output logic             cpuRun,
  output logic             mainClkEn,
  output logic             loopEn,
  output logic             dcGenEn,
  output logic             crystalEn,
  output ivlp_pwr_t        pwrState,
  output logic [7:0]       periphEn
);

  //////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Byte-lane merge of a bus write into a register of up to 16 bits.
  function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    laneMerge = {strb[1] ? data[15:8] : old[15:8],
                 strb[0] ? data[7:0]  : old[7:0]};
  endfunction

  // Highest set bit of the pending vector set; lowest index loses.
  function automatic logic [3:0] topIndex(input logic [15:0] pend);
    topIndex = 4'h0;
    for (int i = 0; i < `IVLP_VEC_CNT; i++)
    begin
      if (pend[i])
      begin
        topIndex = 4'(i);
      end
    end
  endfunction

  // Power state from the four status bits.
  function automatic ivlp_pwr_t pwrDecode(input logic [4:0] st);
    if (!st[`IVLP_ST_HALT])
      pwrDecode = PWR_FULL_RUN_STATE;
    else if (st[`IVLP_ST_XSTOP])
      pwrDecode = PWR_LOW_POWER_FOUR;
    else
    begin
      case ({st[`IVLP_ST_CGHI], st[`IVLP_ST_CGLO]})
        2'h0:    pwrDecode = PWR_LOW_POWER_ZERO;
        2'h1:    pwrDecode = PWR_LOW_POWER_ONE;
        2'h2:    pwrDecode = PWR_LOW_POWER_TWO;
        default: pwrDecode = PWR_LOW_POWER_THREE;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State.

  logic [12:0] ie;                 // Individual interrupt enables.
  logic [12:0] ifg;                // Sticky interrupt flags.
  logic [4:0]  status;             // Status word power and enable bits.
  logic [2:0]  cause;              // Sticky reset causes.
  logic        resetPend;          // Reset vector still to be taken.
  logic [15:0] vtab [16];          // Handler address table.
  logic [15:0] regs [16];          // Processor register file.
  logic [15:0] stkPc [4];          // Saved program counters.
  logic [4:0]  stkSr [4];          // Saved status bits.
  logic [2:0]  stkCnt;             // Entries on the return stack.
  logic        nmiMeta, nmiSync, nmiLast;  // Pin NMI synchroniser.
  logic        rstMeta, rstSync, rstLast;  // Reset pin synchroniser.
  logic [7:0]  awAddrQ;            // Held write address.
  logic        awHeld;             // Write address taken.
  logic [31:0] wDataQ;             // Held write data.
  logic [3:0]  wStrbQ;             // Held write strobes.
  logic        wHeld;              // Write data taken.

  //////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire         doWrite  = awHeld & wHeld & ~s_axi_bvalid;
  wire         arTake   = s_axi_arvalid & s_axi_arready;
  wire         wrVtab   = awAddrQ >= `IVLP_OFF_VTAB &&
                          awAddrQ <= `IVLP_VTAB_LAST;
  wire [3:0]   wrIdx    = awAddrQ[5:2];
  wire         wrIe     = doWrite && awAddrQ == `IVLP_OFF_IE;
  wire         wrIfg    = doWrite && awAddrQ == `IVLP_OFF_IFG;
  wire         wrStat   = doWrite && awAddrQ == `IVLP_OFF_STAT;
  wire         wrModen  = doWrite && awAddrQ == `IVLP_OFF_MODEN;
  wire         wrCause  = doWrite && awAddrQ == `IVLP_OFF_CAUSE;
  wire         wrHit    = wrIe | wrIfg | wrStat | wrModen | wrCause |
                          (doWrite && awAddrQ == `IVLP_OFF_VSTAT) |
                          (doWrite && wrVtab);
  wire [15:0]  wrMerged = laneMerge(16'h0000, wDataQ, wStrbQ);

  //////////////////////////////////////////////////////////////////////////
  // Flag sources and pending vectors.

  wire         gie      = status[`IVLP_ST_GIE];
  wire         nmiEdge  = nmiSync & ~nmiLast;
  wire         rstEdge  = rstSync & ~rstLast;
  wire         tpAny    = tpCounter1Flag | tpCounter2Flag |
                          tpEnableEdgeFlag;
  wire [5:0]   p27Live  = ifg[`IVLP_P27_HI:`IVLP_P27_LO] &
                          ie[`IVLP_P27_HI:`IVLP_P27_LO];
  wire [12:0]  setVec   = {pin27Evt, btEvt, adcEvt, wdtEvt,
                           pin1Evt | timerRxEvt,
                           pin0Evt, oscFaultEvt, nmiEdge};
  // Pending set, one bit per vector position.
  wire [15:0]  pend;
  assign pend[15] = resetPend;
  assign pend[14] = ifg[`IVLP_FG_NMI] |
                    (ifg[`IVLP_FG_OSC] & ie[`IVLP_IE_OSC]);
  assign pend[13] = gie & ie[`IVLP_IE_PIN0] & ifg[`IVLP_FG_PIN0];
  assign pend[12] = gie & ie[`IVLP_IE_PIN1] & ifg[`IVLP_FG_PIN1];
  assign pend[11] = 1'b0;
  assign pend[10] = gie & ie[`IVLP_IE_WDT] & ifg[`IVLP_FG_WDT];
  assign pend[9:6] = 4'h0;
  assign pend[5]  = gie & ie[`IVLP_IE_ADC] & ifg[`IVLP_FG_ADC];
  assign pend[4]  = gie & ie[`IVLP_IE_TP] & tpAny;
  assign pend[3:2] = 2'h0;
  assign pend[1]  = gie & ie[`IVLP_IE_BT] & ifg[`IVLP_FG_BT];
  assign pend[0]  = gie & (|p27Live);

  wire         anyPend  = |pend;
  wire [3:0]   topIdx   = topIndex(pend);
  wire         accept   = irqReq & irqAck;
  wire         popOk    = returnFromHandler && stkCnt != 3'h0;
  wire [1:0]   stkTop   = 2'(stkCnt - 3'h1);

  // Pin zero, ADC and BT vectors drop their flag on acceptance; shared vectors
  // keep theirs so the handler can tell which source fired.
  wire [12:0]  autoClr  = {6'h00, accept && vecNum == `IVLP_PRI_BT,
                           accept && vecNum == `IVLP_PRI_ADC, 2'h0,
                           accept && vecNum == `IVLP_PRI_PIN0,
                           2'h0};
  wire [12:0]  swClr    = wrIfg ? wrMerged[12:0] : 13'h0000;
  // A set in the cycle of its clear survives the clear.
  wire [12:0]  next_ifg = (ifg & ~(swClr | autoClr)) | setVec;

  // Status word: acceptance clears, a return restores, else software.
  wire [4:0]   next_status = accept ? 5'h00 :
                             popOk  ? stkSr[stkTop] :
                             wrStat ? wrMerged[4:0] : status;
  wire [2:0]   causeSet = {wdtResetEvt, rstEdge, 1'b0};
  wire [2:0]   causeClr = wrCause ? wrMerged[2:0] : 3'h0;

  //////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read zero with a slave error.

  wire         rdVtab   = s_axi_araddr >= `IVLP_OFF_VTAB &&
                          s_axi_araddr <= `IVLP_VTAB_LAST;
  wire [31:0]  rdWord   =
    s_axi_araddr == `IVLP_OFF_IE    ? {19'h0, ie} :
    s_axi_araddr == `IVLP_OFF_IFG   ? {19'h0, ifg} :
    s_axi_araddr == `IVLP_OFF_STAT  ? {27'h0, status} :
    s_axi_araddr == `IVLP_OFF_MODEN ? {24'h0, periphEn} :
    s_axi_araddr == `IVLP_OFF_VSTAT ? {24'h0, stkCnt, anyPend, topIdx} :
    s_axi_araddr == `IVLP_OFF_CAUSE ? {29'h0, cause} :
    rdVtab ? {16'h0, vtab[s_axi_araddr[5:2]]} : 32'h0;
  wire         rdHit    = rdVtab ||
                          s_axi_araddr <= `IVLP_OFF_CAUSE &&
                          s_axi_araddr[1:0] == 2'h0;

  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  //////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddrQ      <= 8'h00;
      wDataQ       <= 32'h0;
      wStrbQ       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IVLP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        awHeld  <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wHeld  <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        // The response follows both halves one cycle later.
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `IVLP_RESP_OKAY : `IVLP_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one-cycle answer held until rready.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `IVLP_RESP_OKAY;
    end
    else if (arTake)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdWord;
      s_axi_rresp  <= rdHit ? `IVLP_RESP_OKAY : `IVLP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers for the two pins; only the second and third stages are looked at.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      {nmiMeta, nmiSync, nmiLast} <= 3'h0;
      {rstMeta, rstSync, rstLast} <= 3'h0;
    end
    else
    begin
      {nmiMeta, nmiSync, nmiLast} <= {nmiPin, nmiMeta, nmiSync};
      {rstMeta, rstSync, rstLast} <= {extResetPin, rstMeta, rstSync};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Enables, flags, status, causes and module enables.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ie        <= 13'h0000;
      ifg       <= 13'h0000;
      status    <= 5'h00;
      cause     <= `IVLP_CAUSE_RST;
      resetPend <= 1'b1;
      periphEn  <= 8'h00;
    end
    else
    begin
      if (wrIe)
        ie <= wrMerged[12:0];
      ifg    <= next_ifg;
      status <= next_status;
      cause  <= (cause & ~causeClr) | causeSet;
      // A new reset request wins over the acceptance of the old one.
      resetPend <= (resetPend & ~(accept && vecNum == `IVLP_PRI_RESET))
                   | rstEdge | wdtResetEvt;
      if (wrModen)
        periphEn <= wrMerged[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Vector table entries, one word each, written over the bus.
  for (genvar v = 0; v < `IVLP_VEC_CNT; v++)
  begin : gVtab
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
        vtab[v] <= 16'h0000;
      else if (doWrite && wrVtab && wrIdx == 4'(v))
        vtab[v] <= laneMerge(vtab[v], wDataQ, wStrbQ);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request toward the core; address and handler are registered.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irqReq      <= 1'b0;
      vecNum      <= 4'h0;
      vecAddr     <= `IVLP_VEC_RESET;
      handlerAddr <= 16'h0000;
    end
    else
    begin
      irqReq      <= anyPend & ~accept;
      vecNum      <= topIdx;
      vecAddr     <= `IVLP_VEC_BASE + {11'h0, topIdx, 1'b0};
      handlerAddr <= vtab[topIdx];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Return stack. A push beyond the depth is dropped, so nesting deeper
  // than four returns to the deepest saved mode; a trade for area.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      stkCnt   <= 3'h0;
      returnPc <= 16'h0000;
    end
    else if (accept)
    begin
      if (stkCnt != `IVLP_STK_DEPTH)
        stkCnt <= stkCnt + 3'h1;
    end
    else if (popOk)
    begin
      stkCnt   <= stkTop + 3'h0;
      returnPc <= stkPc[stkTop];
    end
  end

  for (genvar s = 0; s < 4; s++)
  begin : gStack
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
      begin
        stkPc[s] <= 16'h0000;
        stkSr[s] <= 5'h00;
      end
      else if (accept && stkCnt == 3'(s))
      begin
        stkPc[s] <= corePc;
        stkSr[s] <= status;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file; an add of two registers lands in one cycle.
  wire [15:0]  srcVal = regOpSrc == `IVLP_REG_PC ? corePc :
                        regOpSrc == `IVLP_REG_SR ? {11'h0, status} :
                        regOpSrc == `IVLP_REG_CG ? `IVLP_CONST_GEN :
                        regs[regOpSrc];
  wire [15:0]  sumVal = srcVal + regs[regOpDst];

  for (genvar r = 0; r < 16; r++)
  begin : gRegs
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
        regs[r] <= 16'h0000;
      else if (regOpValid && regOpDst == 4'(r))
        regs[r] <= sumVal;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      regOpResult <= 16'h0000;
    else if (regOpValid)
      regOpResult <= sumVal;
  end

  //////////////////////////////////////////////////////////////////////////
  // Power outputs. A pending request wakes the core and main clock so it
  // can take the vector; the loop and generator follow the new status.
  // A halted core with the crystal stopped is level four whatever the
  // generator bits say, so everything behind the crystal stops too.
  wire         deepStop = next_status[`IVLP_ST_HALT] &
                          next_status[`IVLP_ST_XSTOP];
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pwrState  <= PWR_FULL_RUN_STATE;
      cpuRun    <= 1'b1;
      mainClkEn <= 1'b1;
      loopEn    <= 1'b1;
      dcGenEn   <= 1'b1;
      crystalEn <= 1'b1;
    end
    else
    begin
      pwrState  <= pwrDecode(next_status);
      cpuRun    <= ~next_status[`IVLP_ST_HALT] | anyPend;
      mainClkEn <= ~(next_status[`IVLP_ST_CGHI] | deepStop)
                   | anyPend;
      loopEn    <= ~(next_status[`IVLP_ST_CGHI] | deepStop |
                     next_status[`IVLP_ST_CGLO]);
      dcGenEn   <= ~((next_status[`IVLP_ST_CGHI] &
                      next_status[`IVLP_ST_CGLO]) | deepStop);
      crystalEn <= ~next_status[`IVLP_ST_XSTOP];
    end
  end

endmodule

// [ivlp_defines.svh]
// Constants of the interrupt vector and low-power control block.
// Assumes inclusion by bare name.
`ifndef IVLP_DEFINES_SVH
`define IVLP_DEFINES_SVH

// Register byte offsets on the AXI4-Lite port.
`define IVLP_OFF_IE      8'h00
`define IVLP_OFF_IFG     8'h04
`define IVLP_OFF_STAT    8'h08
`define IVLP_OFF_MODEN   8'h0C
`define IVLP_OFF_VSTAT   8'h10
`define IVLP_OFF_CAUSE   8'h14
`define IVLP_OFF_VTAB    8'h40
`define IVLP_VTAB_LAST   8'h7C

// Vector table words and priority numbers.
`define IVLP_VEC_BASE    16'hFFE0
`define IVLP_VEC_RESET   16'hFFFE
`define IVLP_VEC_CNT     16
`define IVLP_PRI_RESET   4'hF
`define IVLP_PRI_PIN0    4'hD
`define IVLP_PRI_ADC     4'h5
`define IVLP_PRI_BT      4'h1

// Status word bit positions.
`define IVLP_ST_GIE      0
`define IVLP_ST_HALT     1
`define IVLP_ST_XSTOP    2
`define IVLP_ST_CGLO     3
`define IVLP_ST_CGHI     4

// Enable and flag bit positions; pin bits 2..7 sit in 12:7.
`define IVLP_IE_OSC      0
`define IVLP_IE_PIN0     1
`define IVLP_IE_PIN1     2
`define IVLP_IE_WDT      3
`define IVLP_IE_ADC      4
`define IVLP_IE_TP       5
`define IVLP_IE_BT       6
`define IVLP_FG_NMI      0
`define IVLP_FG_OSC      1
`define IVLP_FG_PIN0     2
`define IVLP_FG_PIN1     3
`define IVLP_FG_WDT      4
`define IVLP_FG_ADC      5
`define IVLP_FG_BT       6
`define IVLP_P27_LO      7
`define IVLP_P27_HI      12

// Reset cause value after reset: power-up.
`define IVLP_CAUSE_RST   3'h1

// Return stack, register file and bus answers.
`define IVLP_STK_DEPTH   3'h4
`define IVLP_REG_PC      4'h0
`define IVLP_REG_SR      4'h2
`define IVLP_REG_CG      4'h3
`define IVLP_CONST_GEN   16'h0000
`define IVLP_RESP_OKAY   2'h0
`define IVLP_RESP_SLVERR 2'h2

`endif

// [ivlp_pkg.sv]
// Types of the interrupt vector and low-power control block.
// Assumes the constants header sits in the same folder.
package ivlp_pkg;
  // Power states, Gray coded from full run down to level four.
  typedef enum logic [2:0]
  {
    PWR_FULL_RUN_STATE  = 3'h0,
    PWR_LOW_POWER_ZERO  = 3'h1,
    PWR_LOW_POWER_ONE   = 3'h3,
    PWR_LOW_POWER_TWO   = 3'h2,
    PWR_LOW_POWER_THREE = 3'h6,
    PWR_LOW_POWER_FOUR  = 3'h7
  } ivlp_pwr_t;
endpackage

// [ivlp_ctrl_sva.sv]
// Checker of vectoring, accept and power outputs of ivlp_ctrl.
// Assumes it is bound to ivlp_ctrl and sees only its ports.
`timescale 1ns/1ps
`include "ivlp_defines.svh"
module ivlp_ctrl_sva
  import ivlp_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        irqReq,
  input wire logic        irqAck,
  input wire logic [3:0]  vecNum,
  input wire logic [15:0] vecAddr,
  input wire logic        cpuRun,
  input wire logic        mainClkEn,
  input wire logic        loopEn,
  input wire logic        dcGenEn,
  input wire logic        crystalEn,
  input wire ivlp_pwr_t   pwrState
);
  ////////////////////////////////////////////////////////////////////////
  // One clock domain, so clock and disable are given once.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Accepted request, then a full-speed handler.
  sequence s_take;
    irqReq && irqAck;
  endsequence
  sequence s_run;
    !irqReq && cpuRun && (pwrState == PWR_FULL_RUN_STATE);
  endsequence
  a_take_run: assert property (s_take |=> s_run)
    else $error("accept did not clear power state");
  a_vec_addr: assert property (irqReq |->
    vecAddr == `IVLP_VEC_BASE + {11'h000, vecNum, 1'b0})
    else $error("vector address does not match priority");
  a_rst_vec: assert property ($rose(rst_n) |->
    ##[1:2] (irqReq && vecNum == `IVLP_PRI_RESET))
    else $error("no reset vector after release");
  a_full_run: assert property (pwrState == PWR_FULL_RUN_STATE |->
    cpuRun && mainClkEn && loopEn && dcGenEn && crystalEn)
    else $error("full run state with a stopped unit");
  a_lvl_zero: assert property (pwrState == PWR_LOW_POWER_ZERO |->
    mainClkEn && loopEn && dcGenEn && crystalEn)
    else $error("level zero stopped a clock");
  a_loop_off: assert property (pwrState inside {PWR_LOW_POWER_ONE,
    PWR_LOW_POWER_TWO, PWR_LOW_POWER_THREE, PWR_LOW_POWER_FOUR}
    |-> !loopEn)
    else $error("frequency loop runs in low power");
  a_main_off: assert property (!cpuRun && pwrState inside
    {PWR_LOW_POWER_TWO, PWR_LOW_POWER_THREE, PWR_LOW_POWER_FOUR}
    |-> !mainClkEn)
    else $error("main clock runs in deep sleep");
  a_dc_off: assert property (pwrState inside {PWR_LOW_POWER_THREE,
    PWR_LOW_POWER_FOUR} |-> !dcGenEn)
    else $error("dc generator on in level three or four");
  a_xtal_off: assert property
    ((pwrState == PWR_LOW_POWER_FOUR) == !crystalEn)
    else $error("crystal enable disagrees with state");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
endmodule
bind ivlp_ctrl ivlp_ctrl_sva ivlp_ctrl_sva_i (.*);

// [ivlp_core_model.sv]
// Processor core model: takes a pending request when allowed.
// Assumes irqReq comes from ivlp_ctrl on the same clock.
`timescale 1ns/1ps
module ivlp_core_model
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic irqReq,
  input wire logic ackOn,
  output logic     irqAck
);
  ////////////////////////////////////////////////////////////////////////
  // One-cycle acknowledge; holding ackOn low models a slow core.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      irqAck <= 1'b0;
    else
      irqAck <= irqReq && ackOn && !irqAck;
  end
endmodule

// [tb_top.sv]
// Self-checking bench of ivlp_ctrl with a core model on its far side.
// Assumes the checker is bound through its own file.
`timescale 1ns/1ps
module tb_top
  import ivlp_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, ackOn = 0, returnFromHandler = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, regOpValid = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0] s_axi_wstrb = 4'hF, regOpSrc = 0, regOpDst = 0;
  logic [15:0] corePc = 0;
  logic [18:0] evt = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irqReq, irqAck, cpuRun, mainClkEn, loopEn;
  logic dcGenEn, crystalEn, nmiPin, extResetPin, wdtResetEvt;
  logic oscFaultEvt, pin0Evt, pin1Evt, timerRxEvt, wdtEvt, adcEvt;
  logic btEvt, tpCounter1Flag, tpCounter2Flag, tpEnableEdgeFlag;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata;
  logic [3:0] vecNum;
  logic [5:0] pin27Evt;
  logic [7:0] periphEn;
  logic [15:0] vecAddr, handlerAddr, returnPc, regOpResult;
  ivlp_pwr_t pwrState;
  int fails = 0, checked = 0, cyc = 0;
  assign {pin27Evt, tpEnableEdgeFlag, tpCounter2Flag, tpCounter1Flag,
    btEvt, adcEvt, wdtEvt, timerRxEvt, pin1Evt, pin0Evt, oscFaultEvt,
    wdtResetEvt, extResetPin, nmiPin} = evt;
  ivlp_ctrl ivlp_ctrl_i (.*);
  ivlp_core_model ivlp_core_model_i (.*);
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  // A hang ends the run as a failure.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end
  task results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task axWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task axRd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      rd = s_axi_rdata; rr = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  task waitReq(input logic [3:0] v);
    for (int k = 0; k < 50 && irqReq !== 1'b1; k++)
      @(negedge ref_clk);
    chk("vecNum", v, vecNum);
  endtask
  task ack1();
    @(posedge ref_clk) ackOn <= 1;
    do @(negedge ref_clk); while (irqAck !== 1'b1);
    @(posedge ref_clk) ackOn <= 0;
    @(negedge ref_clk);
  endtask
  task ret1();
    @(posedge ref_clk) returnFromHandler <= 1;
    @(posedge ref_clk) returnFromHandler <= 0;
    repeat (2) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task tRst();
    waitReq(4'hF);
    chk("vecAddr", 16'hFFFE, vecAddr);
    ack1();
  endtask
  // Level zero to four status images and their enables.
  task tPwr();
    logic [4:0] st[5] = '{5'h02, 5'h0A, 5'h12, 5'h1A, 5'h1E};
    logic [2:0] ps[5] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h7};
    logic [4:0] en[5] = '{5'h0F, 5'h0B, 5'h03, 5'h01, 5'h00};
    for (int i = 0; i < 5; i++)
    begin
      axWr(8'h08, {27'h0, st[i]});
      repeat (2) @(negedge ref_clk);
      chk("pwrState", ps[i], pwrState);
      chk("enables", en[i], {cpuRun, mainClkEn, loopEn, dcGenEn,
        crystalEn});
    end
  endtask
  // The pin event wakes level four.
  task tWake();
    @(posedge ref_clk) evt[0] <= 1;
    repeat (4) @(posedge ref_clk);
    evt[0] <= 0;
    waitReq(4'hE);
    ack1();
    chk("pwrState", PWR_FULL_RUN_STATE, pwrState);
    axWr(8'h04, 32'h1);
    ret1();
    chk("pwrState", PWR_LOW_POWER_FOUR, pwrState);
  endtask
  task tOsc();
    @(posedge ref_clk) evt[3] <= 1;
    @(posedge ref_clk) evt[3] <= 0;
    repeat (4) @(negedge ref_clk);
    chk("irqReq", 0, irqReq);
    axWr(8'h00, 32'h1);
    waitReq(4'hE);
    axWr(8'h00, 32'h0);
    axWr(8'h04, 32'h2);
  endtask
  // Two requests in one cycle; the lower one waits for the return.
  task tPri();
    axWr(8'h74, 32'h1234);
    axWr(8'h00, 32'h42);
    axWr(8'h08, 32'h1);
    @(posedge ref_clk) evt <= 19'h210;
    @(posedge ref_clk) evt <= 0;
    corePc <= 16'h0ABC;
    waitReq(4'hD);
    chk("handlerAddr", 16'h1234, handlerAddr);
    ack1();
    repeat (3) @(negedge ref_clk);
    chk("irqReq", 0, irqReq);
    ret1();
    chk("returnPc", 16'h0ABC, returnPc);
    waitReq(4'h1);
    ack1();
    ret1();
  endtask
  // Shared, outside-held, watchdog and ADC sources: event bit, vector, flag to clear.
  task tSrc();
    int eb[8] = '{5, 6, 10, 11, 12, 7, 8, 13};
    logic [3:0] vq[8] = '{4'hC, 4'hC, 4'h4, 4'h4, 4'h4, 4'hA, 4'h5, 4'h0};
    int fb[8] = '{3, 3, 0, 0, 0, 4, 5, 7};
    axWr(8'h00, 32'hBC);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk) evt[eb[i]] <= 1;
      waitReq(vq[i]);
      @(posedge ref_clk) evt <= 0;
      axWr(8'h04, 32'h1 << fb[i]);
      repeat (2) @(negedge ref_clk);
      chk("irqReq", 0, irqReq);
    end
  endtask
  task tMisc();
    axWr(8'h0C, 32'hA5);
    axRd(8'h0C);
    chk("periphEn", 8'hA5, periphEn);
    chk("rdata", 32'hA5, rd);
    axRd(8'h20);
    chk("rresp", 2'h2, rr);
    @(posedge ref_clk);
    corePc <= 16'h2468; regOpSrc <= 4'h0; regOpDst <= 4'h3;
    regOpValid <= 1;
    @(posedge ref_clk) regOpValid <= 0;
    @(negedge ref_clk);
    chk("regOpResult", 16'h2468, regOpResult);
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    tRst();
    tPwr();
    tWake();
    tOsc();
    tPri();
    tSrc();
    tMisc();
    results();
  end
endmodule
